// ==== include/efi_pkg.sv ====
package efi_pkg;

  // Register offsets inside one channel's page; the channel nibble sits in addr[15:12].
  localparam logic [11:0] ALARM_ERROR_IRQ_ENABLE_OFS = 12'hb03;
  localparam logic [11:0] FRAMER_IRQ_STATUS_OFS      = 12'hb04;
  localparam logic [11:0] ALARM_CHANGE_STATUS_OFS    = 12'hb0f;
  localparam logic [11:0] FRAMING_CONTROL_OFS        = 12'h10b;
  localparam logic [11:0] SIG_CHANGE_BASE_OFS        = 12'h10d;
  localparam int          SIG_CHANGE_REGS            = 4;

  // Field positions.
  localparam int AIS_EN_BIT    = 1;
  localparam int YEL_EN_BIT    = 0;
  localparam int MF_FLAG_BIT   = 7;
  localparam int NBIT_FLAG_BIT = 6;
  localparam int SIG_FLAG_BIT  = 5;
  localparam int THR_LSB       = 5;
  localparam int THR_MSB       = 6;

  // Values after reset.
  localparam logic [7:0] ENABLE_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // Sizes and counts.
  localparam int SIG_CHANNELS = 30;
  localparam int SA_BITS      = 5;

  typedef enum logic [1:0] {
    EFI_YEL_CLEAR = 2'b01,
    EFI_YEL_SET   = 2'b10
  } efi_yel_e;

endpackage

// ==== core/efi_rx_irq_flags.sv ====
`timescale 1ns/1ps

module efi_rx_irq_flags
  import efi_pkg::*;
#(
  parameter logic [3:0] CHAN_ID = 4'h0
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Host register port.
  input  wire logic [15:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  wdata_i,
  output logic      [7:0]  rdata_o,
  // Enables of the status flags 7, 6 and 5.
  input  wire logic [2:0]  status_irq_enable_i,
  // Receive datapath events.
  input  wire logic        cas_en_i,
  input  wire logic        ais_i,
  input  wire logic        nonfas_stb_i,
  input  wire logic        a_bit_i,
  input  wire logic [4:0]  sa_bits_i,
  input  wire logic        mfas_stb_i,
  input  wire logic        mfas_err_i,
  input  wire logic        sig_stb_i,
  input  wire logic [4:0]  sig_chan_i,
  input  wire logic [3:0]  sig_abcd_i,
  // Status and interrupt.
  output logic             yellow_state_o,
  output logic             cas_mf_loss_o,
  output logic             irq_o
);

  logic [7:0]              alarm_error_irq_enable;
  logic [7:0]              framing_control_reg;
  logic                    cas_mf_align_change_flag;
  logic                    national_bits_change_flag;
  logic                    cas_signaling_change_flag;
  logic                    ais_change_flag;
  logic                    yellow_change_flag;
  logic                    ais_q;
  logic                    prev_a_bit;
  efi_yel_e                yel_state;
  logic [2:0]              mf_err_cnt;
  logic [SA_BITS-1:0]      prev_sa;
  logic                    sa_valid;
  logic [3:0]              sig_store [SIG_CHANNELS];
  logic [SIG_CHANNELS-1:0] sig_seen;
  logic [31:0]             sig_bank;
  logic                    ais_evt;
  logic                    yel_evt;
  logic                    mf_evt;
  logic                    nb_evt;
  logic                    sig_evt;
  logic                    page_hit;
  logic [1:0]              cas_mf_loss_threshold;
  logic                    next_irq;

  function automatic logic reg_hit(input logic [11:0] ofs);
    reg_hit = page_hit && (addr_i[11:0] == ofs);
  endfunction

  assign page_hit              = (addr_i[15:12] == CHAN_ID);
  assign cas_mf_loss_threshold = framing_control_reg[THR_MSB:THR_LSB];
  assign ais_evt = (ais_i != ais_q);
  assign yel_evt = nonfas_stb_i && (a_bit_i == prev_a_bit) &&
                   ((yel_state == EFI_YEL_SET) != a_bit_i);
  assign mf_evt  = mfas_stb_i && cas_en_i &&
                   (mfas_err_i ? (!cas_mf_loss_o && mf_err_cnt >= {1'b0, cas_mf_loss_threshold})
                               : cas_mf_loss_o);
  assign nb_evt  = nonfas_stb_i && sa_valid && (sa_bits_i != prev_sa);
  assign sig_evt = sig_stb_i && (sig_chan_i < 5'(SIG_CHANNELS)) && sig_seen[sig_chan_i] &&
                   (sig_abcd_i != sig_store[sig_chan_i]);

  // Writable control registers.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alarm_error_irq_enable <= ENABLE_RST;
      framing_control_reg    <= CONTROL_RST;
    end else if (wr_i) begin
      if (reg_hit(ALARM_ERROR_IRQ_ENABLE_OFS)) begin
        alarm_error_irq_enable <= wdata_i;
      end
      if (reg_hit(FRAMING_CONTROL_OFS)) begin
        framing_control_reg <= wdata_i;
      end
    end
  end

  // AIS level tracking.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ais_q <= 1'b0;
    end else begin
      ais_q <= ais_i;
    end
  end

  // Yellow alarm detector on consecutive non-FAS A bits.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_a_bit     <= 1'b0;
      yel_state      <= EFI_YEL_CLEAR;
      yellow_state_o <= 1'b0;
    end else if (nonfas_stb_i) begin
      prev_a_bit <= a_bit_i;
      case (yel_state)
        EFI_YEL_CLEAR: begin
          if (a_bit_i && prev_a_bit) begin
            yel_state      <= EFI_YEL_SET;
            yellow_state_o <= 1'b1;
          end
        end
        EFI_YEL_SET: begin
          if (!a_bit_i && !prev_a_bit) begin
            yel_state      <= EFI_YEL_CLEAR;
            yellow_state_o <= 1'b0;
          end
        end
        default: begin
          yel_state      <= EFI_YEL_CLEAR;
          yellow_state_o <= 1'b0;
        end
      endcase
    end
  end

  // CAS multiframe alignment loss; one good alignment word clears it.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mf_err_cnt    <= 3'h0;
      cas_mf_loss_o <= 1'b0;
    end else if (!cas_en_i) begin
      mf_err_cnt    <= 3'h0;
      cas_mf_loss_o <= 1'b0;
    end else if (mfas_stb_i) begin
      if (mfas_err_i) begin
        if (mf_err_cnt != 3'h4) begin
          mf_err_cnt <= mf_err_cnt + 3'h1;
        end
        if (mf_err_cnt >= {1'b0, cas_mf_loss_threshold}) begin
          cas_mf_loss_o <= 1'b1;
        end
      end else begin
        mf_err_cnt    <= 3'h0;
        cas_mf_loss_o <= 1'b0;
      end
    end
  end

  // National bit history.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_sa  <= 5'h00;
      sa_valid <= 1'b0;
    end else if (nonfas_stb_i) begin
      prev_sa  <= sa_bits_i;
      sa_valid <= 1'b1;
    end
  end

  // Signaling history and per-channel change bank; a bank read clears its byte.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sig_seen <= '0;
      sig_bank <= 32'h0000_0000;
      for (int i = 0; i < SIG_CHANNELS; i++) begin
        sig_store[i] <= 4'h0;
      end
    end else begin
      for (int k = 0; k < SIG_CHANGE_REGS; k++) begin
        if (rd_i && reg_hit(SIG_CHANGE_BASE_OFS + 12'(k))) begin
          sig_bank[k*8 +: 8] <= 8'h00;
        end
      end
      if (sig_stb_i && (sig_chan_i < 5'(SIG_CHANNELS))) begin
        sig_store[sig_chan_i] <= sig_abcd_i;
        sig_seen[sig_chan_i]  <= 1'b1;
        if (sig_evt) begin
          sig_bank[sig_chan_i] <= 1'b1;
        end
      end
    end
  end

  // Sticky flags; an event in the read cycle wins over the clear.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cas_mf_align_change_flag  <= 1'b0;
      national_bits_change_flag <= 1'b0;
      cas_signaling_change_flag <= 1'b0;
      ais_change_flag           <= 1'b0;
      yellow_change_flag        <= 1'b0;
    end else begin
      if (rd_i && reg_hit(FRAMER_IRQ_STATUS_OFS)) begin
        cas_mf_align_change_flag  <= mf_evt;
        national_bits_change_flag <= nb_evt;
        cas_signaling_change_flag <= sig_evt;
      end else begin
        cas_mf_align_change_flag  <= cas_mf_align_change_flag | mf_evt;
        national_bits_change_flag <= national_bits_change_flag | nb_evt;
        cas_signaling_change_flag <= cas_signaling_change_flag | sig_evt;
      end
      if (rd_i && reg_hit(ALARM_CHANGE_STATUS_OFS)) begin
        ais_change_flag    <= ais_evt;
        yellow_change_flag <= yel_evt;
      end else begin
        ais_change_flag    <= ais_change_flag | ais_evt;
        yellow_change_flag <= yellow_change_flag | yel_evt;
      end
    end
  end

  // Multiframe and signaling flags count only while CAS is enabled.
  always_comb begin
    next_irq = (ais_change_flag && alarm_error_irq_enable[AIS_EN_BIT]) ||
               (yellow_change_flag && alarm_error_irq_enable[YEL_EN_BIT]) ||
               (cas_mf_align_change_flag && status_irq_enable_i[2] && cas_en_i) ||
               (national_bits_change_flag && status_irq_enable_i[1]) ||
               (cas_signaling_change_flag && status_irq_enable_i[0] && cas_en_i);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

  // Read data, registered one cycle after the read strobe.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= 8'h00;
      if (reg_hit(ALARM_ERROR_IRQ_ENABLE_OFS)) begin
        rdata_o <= alarm_error_irq_enable;
      end
      if (reg_hit(FRAMING_CONTROL_OFS)) begin
        rdata_o <= framing_control_reg;
      end
      if (reg_hit(FRAMER_IRQ_STATUS_OFS)) begin
        rdata_o <= {cas_mf_align_change_flag, national_bits_change_flag,
                    cas_signaling_change_flag, 5'h00};
      end
      if (reg_hit(ALARM_CHANGE_STATUS_OFS)) begin
        rdata_o <= {6'h00, ais_change_flag, yellow_change_flag};
      end
      for (int k = 0; k < SIG_CHANGE_REGS; k++) begin
        if (reg_hit(SIG_CHANGE_BASE_OFS + 12'(k))) begin
          rdata_o <= sig_bank[k*8 +: 8];
        end
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  yel_declare_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (nonfas_stb_i && a_bit_i && prev_a_bit && yel_state == EFI_YEL_CLEAR)
    |=> yellow_state_o && yellow_change_flag)
    else $error("yellow alarm not declared after two A ones");

  yel_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (nonfas_stb_i && !a_bit_i && !prev_a_bit) |=> !yellow_state_o)
    else $error("yellow alarm not cleared after two A zeros");

  ais_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ais_i != $past(ais_i)) && $past(nrst_i) |=> ais_change_flag)
    else $error("AIS change not recorded");

  mf_loss_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (cas_en_i && mfas_stb_i && mfas_err_i && !cas_mf_loss_o &&
     mf_err_cnt == {1'b0, cas_mf_loss_threshold}) |=> cas_mf_loss_o && cas_mf_align_change_flag)
    else $error("CAS multiframe loss not declared at threshold");

  nbit_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (nonfas_stb_i && sa_valid && sa_bits_i != prev_sa) |=> national_bits_change_flag)
    else $error("national bit change not flagged");

  sig_bank_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sig_evt |=> sig_bank[$past(sig_chan_i)] && cas_signaling_change_flag)
    else $error("signaling change bank bit missing");

  read_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (rd_i && reg_hit(FRAMER_IRQ_STATUS_OFS) && !mf_evt && !nb_evt && !sig_evt)
    |=> !cas_mf_align_change_flag && !national_bits_change_flag && !cas_signaling_change_flag)
    else $error("status flags not cleared by read");

  irq_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (alarm_error_irq_enable[1:0] == 2'b00 && status_irq_enable_i == 3'b000) |=> !irq_o)
    else $error("interrupt raised with all enables off");

  irq_follow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (national_bits_change_flag && status_irq_enable_i[1]) |=> irq_o)
    else $error("interrupt missing for enabled flag");

endmodule

// ==== verif/efi_host_model.sv ====
`timescale 1ns/1ps

// Host processor: one-cycle strobes, read data taken the cycle after the strobe.
module efi_host_model (
  // Clock and register port.
  input  wire logic        clk_i,
  output logic      [15:0] addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [7:0]  wdata_o,
  input  wire logic [7:0]  rdata_i
);
  initial begin
    addr_o = 16'hffff;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  task automatic access(input logic [15:0] a, input bit w, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wr_o = w;
    rd_o = !w;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    q = rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
endmodule

// ==== verif/e1_rx_framer_irq_flags_bench.sv ====
`timescale 1ns/1ps

module e1_rx_framer_irq_flags_bench;
  import efi_pkg::*;

  logic        clk_i = 1'b0, nrst_i = 1'b0, wr, rd;
  logic [15:0] addr;
  logic [15:0] lf = 16'ha1b6;
  logic [7:0]  wdata, rdata;
  logic [7:0]  en = 8'h00;
  logic [2:0]  se = 3'h0;
  logic        cas_en = 1'b1, ais = 1'b0, nonfas = 1'b0, a_bit = 1'b0;
  logic        mfas = 1'b0, merr = 1'b0, sig = 1'b0, yel_st, loss_st, irq;
  logic [4:0]  sa = 5'h00, chan = 5'h00;
  logic [3:0]  abcd = 4'h0;
  bit          yel, pa, ais_p, ych, aisch, mf, nb, sg, loss, nprim;
  bit   [4:0]  psa;
  int          cnt, thr, failures, checked, cycles;
  int          sprim[30], sprev[30], bank[30];

  efi_rx_irq_flags u_dut (
    .clk_i              (clk_i),
    .nrst_i             (nrst_i),
    .addr_i             (addr),
    .wr_i               (wr),
    .rd_i               (rd),
    .wdata_i            (wdata),
    .rdata_o            (rdata),
    .status_irq_enable_i(se),
    .cas_en_i           (cas_en),
    .ais_i              (ais),
    .nonfas_stb_i       (nonfas),
    .a_bit_i            (a_bit),
    .sa_bits_i          (sa),
    .mfas_stb_i         (mfas),
    .mfas_err_i         (merr),
    .sig_stb_i          (sig),
    .sig_chan_i         (chan),
    .sig_abcd_i         (abcd),
    .yellow_state_o     (yel_st),
    .cas_mf_loss_o      (loss_st),
    .irq_o              (irq)
  );

  efi_host_model u_host (
    .clk_i  (clk_i),
    .addr_o (addr),
    .wr_o   (wr),
    .rd_o   (rd),
    .wdata_o(wdata),
    .rdata_i(rdata)
  );

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 10000) begin
      failures++;
      conclude();
    end
  end

  function automatic logic [15:0] nxt();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A write when w is set, otherwise a read compared with d.
  task automatic acc(input logic [15:0] a, input bit w, input logic [7:0] d);
    logic [7:0] q;
    u_host.access(a, w, d, q);
    if (!w) chk(q, d);
  endtask

  // One cycle of datapath events; the reference model follows each event.
  task automatic step(input bit busy);
    logic [15:0] r;
    logic [15:0] s;
    @(posedge clk_i);
    #1;
    chk(8'(yel_st), 8'(yel));
    chk(8'(loss_st), 8'(loss));
    r = nxt();
    s = nxt();
    nonfas = busy & r[0];
    a_bit = r[1];
    if (r[2]) sa = r[7:3];
    mfas = busy & r[8];
    merr = r[9] | r[10];
    sig = busy & r[11];
    chan = s[4:0];
    if (s[5] & s[6]) abcd = s[10:7];
    if (busy & r[12] & r[13] & r[14]) ais = ~ais;
    if (ais != ais_p) aisch = 1'b1;
    ais_p = ais;
    if (nonfas) begin
      if (a_bit == pa && a_bit != yel) ych = 1'b1;
      if (a_bit == pa) yel = a_bit;
      pa = a_bit;
      if (nprim && sa != psa) nb = 1'b1;
      psa = sa;
      nprim = 1'b1;
    end
    if (!cas_en) cnt = 0;
    if (mfas && cas_en && !merr) begin
      if (loss) mf = 1'b1;
      loss = 1'b0;
      cnt = 0;
    end
    if (mfas && cas_en && merr) begin
      if (!loss && cnt >= thr) mf = 1'b1;
      if (cnt >= thr) loss = 1'b1;
      cnt++;
    end
    if (sig && chan < 30) begin
      if (sprim[chan] != 0 && sprev[chan] != abcd) begin
        sg = 1'b1;
        bank[chan] = 1;
      end
      sprev[chan] = abcd;
      sprim[chan] = 1;
    end
  endtask

  initial begin
    logic [15:0] r;
    logic [7:0]  b;
    repeat (12) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    acc({4'h0, ALARM_ERROR_IRQ_ENABLE_OFS}, 1'b0, 8'h00);
    acc({4'h0, FRAMER_IRQ_STATUS_OFS}, 1'b0, 8'h00);
    for (int p = 0; p < 40; p++) begin
      r = nxt();
      acc({4'h0, FRAMER_IRQ_STATUS_OFS}, 1'b1, 8'hff);
      en = r[7:0];
      thr = r[9:8];
      acc({4'h0, ALARM_ERROR_IRQ_ENABLE_OFS}, 1'b1, en);
      // A write to another channel's page must leave this enable untouched.
      acc(16'h1b03, 1'b1, ~en);
      acc({4'h0, FRAMING_CONTROL_OFS}, 1'b1, {1'b0, r[9:8], 5'h00});
      se = r[12:10];
      if (!loss) cas_en = r[13] | r[14];
      repeat (24) step(1'b1);
      repeat (3) step(1'b0);
      chk(8'(irq), 8'((aisch & en[1]) | (ych & en[0]) | (nb & se[1])
          | (cas_en & ((mf & se[2]) | (sg & se[0])))));
      // Another channel's page and an unmapped offset must neither answer nor clear.
      acc(16'h1b04, 1'b0, 8'h00);
      acc(16'h0b00, 1'b0, 8'h00);
      acc({4'h0, ALARM_CHANGE_STATUS_OFS}, 1'b0, {6'h00, aisch, ych});
      acc({4'h0, FRAMER_IRQ_STATUS_OFS}, 1'b0, {mf, nb, sg, 5'h00});
      for (int k = 0; k < SIG_CHANGE_REGS; k++) begin
        b = 8'h00;
        for (int j = 0; j < 8; j++) if (8 * k + j < 30) b[j] = bank[8 * k + j][0];
        acc({4'h0, SIG_CHANGE_BASE_OFS + 12'(k)}, 1'b0, b);
      end
      acc({4'h0, ALARM_ERROR_IRQ_ENABLE_OFS}, 1'b0, en);
      acc({4'h0, FRAMING_CONTROL_OFS}, 1'b0, {1'b0, r[9:8], 5'h00});
      {ych, aisch, mf, nb, sg} = 5'h00;
      bank = '{default: 0};
      repeat (2) step(1'b0);
      chk(8'(irq), 8'h00);
    end
    conclude();
  end
endmodule
